// File: logic/tpecr_top.sv
`timescale 1ns/100ps
module tpecr_top #(
  parameter int CNT_W = tpecr_pkg::WIDE_CNT_W
) (
  input  wire logic             CORE_CLK,
  input  wire logic             SYS_RST,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  input  wire logic             REG_WE,
  input  wire logic             REG_RE,
  output logic      [7:0]       REG_RDATA,
  input  wire logic [CNT_W-1:0] ERR_COUNT_RUN,
  input  wire logic             TIMEBASE_DONE,
  input  wire logic             CONTINUOUS_MODE,
  input  wire logic             TX_LOCK_LOST_FLAG,
  input  wire logic [6:0]       INTERNAL_LOOP_FILTER,
  output logic [CNT_W-1:0]      TX_PATTERN_ERROR_WIDE_COUNT,
  output logic [1:0]            HIGH_SPEED_POWER_BITS,
  output logic [2:0]            OUTPUT_SWING_SELECT,
  output logic [2:0]            ACQ_PHASE_DET_GAIN,
  output logic [4:0]            ACQ_GAIN_TRIM,
  output logic [6:0]            LOOP_FILTER_IN_USE,
  output logic                  LOOP_FILTER_OVERRIDE_SELECT
);

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0]       rdata;
    logic [7:0]       swing;
    logic [7:0]       gain;
    logic [7:0]       loopf;
    logic [CNT_W-1:0] wide_cnt;
    logic [7:0]       err_float;
    logic [6:0]       lf_used;
  } tpecr_state_s;

  tpecr_state_s st_ff;
  tpecr_state_s nxt_st;
  logic [7:0]   enc_float;

  //////////////////////////////////////////////////////////////////////////
  // compression of the held count

  tpecr_float_enc #(
    .CNT_W     (CNT_W)
  ) u_float_enc (
    .count     (st_ff.wide_cnt),
    .float_val (enc_float)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;

    // hold last completed window unless running continuously
    if (CONTINUOUS_MODE) begin
      nxt_st.wide_cnt = ERR_COUNT_RUN;
    end else if (TIMEBASE_DONE) begin
      nxt_st.wide_cnt = ERR_COUNT_RUN;
    end

    // float lags the wide count by one cycle
    nxt_st.err_float = enc_float;

    // register writes; untouched fields keep their value
    if (REG_WE) begin
      if (REG_ADDR == tpecr_pkg::ADDR_SWING) begin
        // reserved middle bits never stored
        nxt_st.swing = REG_WDATA & tpecr_pkg::SWING_WR_MASK;
      end else if (REG_ADDR == tpecr_pkg::ADDR_PD_GAIN) begin
        nxt_st.gain = REG_WDATA;
      end else if (REG_ADDR == tpecr_pkg::ADDR_LOOP_F) begin
        nxt_st.loopf = REG_WDATA;
      end
    end

    // select programmed or internal filter setting
    if (st_ff.loopf[tpecr_pkg::LOOPF_SEL_BIT]) begin
      nxt_st.lf_used = st_ff.loopf[6:0];
    end else begin
      nxt_st.lf_used = INTERNAL_LOOP_FILTER;
    end

    // read data registered; one cycle after the strobe
    if (REG_RE) begin
      if (REG_ADDR == tpecr_pkg::ADDR_ERR_FLOAT) begin
        nxt_st.rdata = st_ff.err_float;
      end else if (REG_ADDR == tpecr_pkg::ADDR_SWING) begin
        nxt_st.rdata = st_ff.swing; // bits 5:3 read zero
      end else if (REG_ADDR == tpecr_pkg::ADDR_PD_GAIN) begin
        nxt_st.rdata = st_ff.gain;
      end else if (REG_ADDR == tpecr_pkg::ADDR_LOOP_F) begin
        // shows the setting in use, not the write
        nxt_st.rdata = {st_ff.loopf[tpecr_pkg::LOOPF_SEL_BIT],
                        st_ff.lf_used};
      end else begin
        nxt_st.rdata = tpecr_pkg::UNMAPPED_RD;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  // count and float cleared anyway; software must not rely on it
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_ff.rdata     <= tpecr_pkg::RDATA_RST;
      st_ff.swing     <= tpecr_pkg::SWING_RST;
      st_ff.gain      <= tpecr_pkg::GAIN_RST;
      st_ff.loopf     <= tpecr_pkg::LOOPF_RST;
      st_ff.wide_cnt  <= '0;
      st_ff.err_float <= 8'h00;
      st_ff.lf_used   <= 7'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign REG_RDATA                   = st_ff.rdata;
  assign TX_PATTERN_ERROR_WIDE_COUNT = st_ff.wide_cnt;
  assign HIGH_SPEED_POWER_BITS       = st_ff.swing[tpecr_pkg::SWING_PWR_LSB +: 2];
  assign OUTPUT_SWING_SELECT         =
    st_ff.swing[tpecr_pkg::SWING_SEL_LSB +: 3];
  assign ACQ_PHASE_DET_GAIN          =
    st_ff.gain[tpecr_pkg::GAIN_FLD_LSB +: 3];
  assign ACQ_GAIN_TRIM               = st_ff.gain[4:0];
  assign LOOP_FILTER_IN_USE          = st_ff.lf_used;
  assign LOOP_FILTER_OVERRIDE_SELECT =
    st_ff.loopf[tpecr_pkg::LOOPF_SEL_BIT];

endmodule // tpecr_top

// File: shared/tpecr_pkg.sv
package tpecr_pkg;

  // register offsets on the management port
  localparam logic [7:0] ADDR_ERR_FLOAT  = 8'hb5;
  localparam logic [7:0] ADDR_SWING      = 8'hb8;
  localparam logic [7:0] ADDR_PD_GAIN    = 8'hcd;
  localparam logic [7:0] ADDR_LOOP_F     = 8'he2;

  // field widths
  localparam int WIDE_CNT_W  = 40;
  localparam int NIB_CNT     = WIDE_CNT_W / 4;

  // swing register layout
  localparam int SWING_PWR_LSB   = 6;
  localparam int SWING_SEL_LSB   = 0;
  localparam logic [7:0] SWING_WR_MASK = 8'hc7;

  // phase detector gain layout
  localparam int GAIN_FLD_LSB    = 5;

  // loop filter layout
  localparam int LOOPF_SEL_BIT   = 7;

  // reset values
  localparam logic [7:0] SWING_RST  = 8'hc0;
  localparam logic [7:0] GAIN_RST   = 8'h8d;
  localparam logic [7:0] LOOPF_RST  = 8'h00;
  localparam logic [7:0] RDATA_RST  = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

endpackage

// File: logic/tpecr_float_enc.sv
`timescale 1ns/100ps
// compresses a wide count into mantissa/exponent, base 16
module tpecr_float_enc #(
  parameter int CNT_W = 40
) (
  input  wire logic [CNT_W-1:0] count,
  output logic      [7:0]       float_val
);

  localparam int NIBS = CNT_W / 4;

  // top nonzero nibble is the mantissa; lower nibbles are truncated
  always_comb begin
    float_val = 8'h00; // zero count encodes as all zero
    for (int i = 0; i < NIBS; i++) begin
      if (count[i*4 +: 4] != 4'h0) begin
        float_val[7:4] = count[i*4 +: 4];
        float_val[3:0] = 4'(i + 1);
      end
    end
  end

endmodule // tpecr_float_enc

// File: tb/tpecr_checker.sv
`timescale 1ns/100ps
module tpecr_checker (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WE,
  input wire logic        REG_RE,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [39:0] ERR_COUNT_RUN,
  input wire logic        TIMEBASE_DONE,
  input wire logic        CONTINUOUS_MODE,
  input wire logic [6:0]  INTERNAL_LOOP_FILTER,
  input wire logic [39:0] TX_PATTERN_ERROR_WIDE_COUNT,
  input wire logic [1:0]  HIGH_SPEED_POWER_BITS,
  input wire logic [2:0]  OUTPUT_SWING_SELECT,
  input wire logic [2:0]  ACQ_PHASE_DET_GAIN,
  input wire logic [4:0]  ACQ_GAIN_TRIM,
  input wire logic [6:0]  LOOP_FILTER_IN_USE,
  input wire logic        LOOP_FILTER_OVERRIDE_SELECT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // write strokes per register
  wire ws = REG_WE && REG_ADDR == tpecr_pkg::ADDR_SWING;
  wire wg = REG_WE && REG_ADDR == tpecr_pkg::ADDR_PD_GAIN;
  wire wl = REG_WE && REG_ADDR == tpecr_pkg::ADDR_LOOP_F;
  wire tk = CONTINUOUS_MODE || TIMEBASE_DONE;
  a_swing_write: assert property (ws |=> OUTPUT_SWING_SELECT ==
    $past(REG_WDATA[2:0]) && HIGH_SPEED_POWER_BITS == $past(REG_WDATA[7:6]))
    else $error("swing write lost");
  a_swing_hold: assert property (!ws |=>
    $stable({HIGH_SPEED_POWER_BITS, OUTPUT_SWING_SELECT}))
    else $error("swing changed without write");
  a_gain_write: assert property (wg |=>
    {ACQ_PHASE_DET_GAIN, ACQ_GAIN_TRIM} == $past(REG_WDATA))
    else $error("gain write lost");
  a_gain_reset: assert property ($fell(SYS_RST) |->
    {ACQ_PHASE_DET_GAIN, ACQ_GAIN_TRIM} == 8'h8d) else $error("gain reset");
  a_read_swing: assert property (REG_RE && REG_ADDR ==
    tpecr_pkg::ADDR_SWING |=> REG_RDATA == {$past(HIGH_SPEED_POWER_BITS),
    3'h0, $past(OUTPUT_SWING_SELECT)}) else $error("swing readback");
  a_rdata_hold: assert property (!REG_RE |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_wide_take: assert property (tk |=>
    TX_PATTERN_ERROR_WIDE_COUNT == $past(ERR_COUNT_RUN))
    else $error("wide count not taken");
  a_wide_hold: assert property (!tk |=>
    $stable(TX_PATTERN_ERROR_WIDE_COUNT)) else $error("wide count moved");
  a_lf_internal: assert property (!LOOP_FILTER_OVERRIDE_SELECT |=>
    LOOP_FILTER_IN_USE == $past(INTERNAL_LOOP_FILTER))
    else $error("internal loop value unused");
  a_ovr_write: assert property (wl |=>
    LOOP_FILTER_OVERRIDE_SELECT == $past(REG_WDATA[7]))
    else $error("override write lost");
endmodule // tpecr_checker
bind tpecr_top tpecr_checker i_tpecr_checker (.*);

// File: tb/tpecr_top_tb_top.sv
`timescale 1ns/100ps
module tpecr_top_tb_top;
  logic        CORE_CLK, SYS_RST, REG_WE, REG_RE, TIMEBASE_DONE;
  logic        CONTINUOUS_MODE, TX_LOCK_LOST_FLAG, LOOP_FILTER_OVERRIDE_SELECT;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, rd_val;
  logic [39:0] ERR_COUNT_RUN, TX_PATTERN_ERROR_WIDE_COUNT;
  logic [6:0]  INTERNAL_LOOP_FILTER, LOOP_FILTER_IN_USE;
  logic [2:0]  OUTPUT_SWING_SELECT, ACQ_PHASE_DET_GAIN;
  logic [1:0]  HIGH_SPEED_POWER_BITS;
  logic [4:0]  ACQ_GAIN_TRIM;
  int          errors = 0, comparisons = 0, cycles = 0;
  tpecr_top i_tpecr_top (.*);
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end
  task chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
      errors++;
    end
  endtask
  // one strobe cycle each; strobes drop before the next task starts
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    {REG_ADDR, REG_WDATA, REG_WE} <= {a, d, 1'b1};
    @(posedge CORE_CLK);
    REG_WE <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge CORE_CLK);
    {REG_ADDR, REG_RE} <= {a, 1'b1};
    @(posedge CORE_CLK);
    REG_RE <= 1'b0;
    @(posedge CORE_CLK);
    rd_val = REG_RDATA;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_swing;
    for (int i = 0; i < 8; i++) begin
      wr(tpecr_pkg::ADDR_SWING, {5'h1f, i[2:0]});
      rd(tpecr_pkg::ADDR_SWING);
      chk(rd_val, {5'h18, i[2:0]});
      chk(OUTPUT_SWING_SELECT, i[2:0]);
    end
  endtask
  task t_gain;
    rd(tpecr_pkg::ADDR_PD_GAIN);
    chk(rd_val, 8'h8d);
    wr(tpecr_pkg::ADDR_PD_GAIN, 8'h0d);
    rd(tpecr_pkg::ADDR_PD_GAIN);
    chk({ACQ_PHASE_DET_GAIN, ACQ_GAIN_TRIM, rd_val}, 16'h0d0d);
  endtask
  // override while loop filter register bit 7 is set, then back to internal value once it is cleared
  task t_loopf;
    {TX_LOCK_LOST_FLAG, INTERNAL_LOOP_FILTER} <= {1'b1, 7'h2a};
    wr(tpecr_pkg::ADDR_LOOP_F, 8'h98);
    rd(tpecr_pkg::ADDR_LOOP_F);
    chk({rd_val, LOOP_FILTER_IN_USE}, {8'h98, 7'h18});
    TX_LOCK_LOST_FLAG <= 1'b0;
    wr(tpecr_pkg::ADDR_LOOP_F, 8'h00);
    rd(tpecr_pkg::ADDR_LOOP_F);
    chk(rd_val, 8'h2a);
  endtask
  task t_count;
    {ERR_COUNT_RUN, TIMEBASE_DONE} <= {40'h57, 1'b1};
    @(posedge CORE_CLK);
    {ERR_COUNT_RUN, TIMEBASE_DONE} <= {40'h1, 1'b0};
    wr(tpecr_pkg::ADDR_ERR_FLOAT, 8'hff);
    chk(TX_PATTERN_ERROR_WIDE_COUNT, 40'h57);
    rd(tpecr_pkg::ADDR_ERR_FLOAT);
    chk(rd_val, 8'h52);
    {ERR_COUNT_RUN, CONTINUOUS_MODE} <= {40'ha123, 1'b1};
    rd(tpecr_pkg::ADDR_ERR_FLOAT);
    rd(tpecr_pkg::ADDR_ERR_FLOAT);
    chk({TX_PATTERN_ERROR_WIDE_COUNT, rd_val}, {40'ha123, 8'ha4});
    rd(8'h10);
    chk(rd_val, tpecr_pkg::UNMAPPED_RD);
  endtask
  task print_verdict;
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well above the fewer than 100 cycles the tests need
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    {SYS_RST, REG_WE, REG_RE, TIMEBASE_DONE, CONTINUOUS_MODE} = 5'h10;
    {TX_LOCK_LOST_FLAG, REG_ADDR, REG_WDATA} = 17'h0;
    {ERR_COUNT_RUN, INTERNAL_LOOP_FILTER} = 47'h0;
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    t_gain;
    t_swing;
    t_loopf;
    t_count;
    print_verdict;
  end
endmodule // tpecr_top_tb_top
